// ---- rtl/ram_clock_map.svh ----
// offsets, field positions and reset values of the ram clocking block
// assumes a 32-bit apb with word-aligned byte addresses
`ifndef RAM_CLOCK_MAP_SVH
`define RAM_CLOCK_MAP_SVH

`define RCM_CFG_OFFSET      12'h000
`define RCM_STATUS_OFFSET   12'h004
`define RCM_PORTMODE_BIT    0
`define RCM_METHOD_LSB      1
`define RCM_METHOD_MSB      2
`define RCM_RDENA_BIT       3
`define RCM_RDENB_BIT       4
`define RCM_REJECT_BIT      0
`define RCM_STAT_CFG_LSB    8
`define RCM_STAT_CFG_MSB    12
`define RCM_CFG_RESET       5'h00
`define RCM_METHOD_ILLEGAL  2'h3

`endif

// ---- rtl/ram_clock_pkg.sv ----
// types used by the ram clocking block; its memory array uses none of them
// assumes the map header supplies offsets and field positions
package ram_clock_pkg;

   typedef enum logic [0:0] {
      SIMPLE_DUAL,
      TRUE_DUAL
   } portMode_e;

   typedef enum logic [1:0] {
      CLK_SINGLE,
      CLK_IN_OUT,
      CLK_SEPARATE
   } clkMethod_e;

   typedef struct packed {
      logic       rdEnCreateB;
      logic       rdEnCreateA;
      clkMethod_e clkMethod;
      portMode_e  portMode;
   } cfg_s;

endpackage : ram_clock_pkg

// ---- rtl/ram_dual_mem.sv ----
// two-port memory array with registered read data
// assumes strobes are one-cycle enables synchronous to clk
`timescale 1ns/1ps

module ram_dual_mem #(
   parameter int ADDR_W = 8,
   parameter int DATA_W = 16
) (
   input  wire logic              clk,
   input  wire logic              rst_n,
   input  wire logic              wrStbA,
   input  wire logic [ADDR_W-1:0] wrAddrA,
   input  wire logic [DATA_W-1:0] wrDataA,
   input  wire logic              rdStbA,
   input  wire logic [ADDR_W-1:0] rdAddrA,
   output logic      [DATA_W-1:0] rdDataA,
   input  wire logic              wrStbB,
   input  wire logic [ADDR_W-1:0] wrAddrB,
   input  wire logic [DATA_W-1:0] wrDataB,
   input  wire logic              rdStbB,
   input  wire logic [ADDR_W-1:0] rdAddrB,
   output logic      [DATA_W-1:0] rdDataB
);

   logic [DATA_W-1:0] memArray [0:(1<<ADDR_W)-1];

   if (ADDR_W < 1 || ADDR_W > 16) begin : g_chkA
      $error("ram_dual_mem: ADDR_W out of range");
   end
   if (DATA_W < 1) begin : g_chkD
      $error("ram_dual_mem: DATA_W out of range");
   end

   // port a write wins when both ports write one word
   always_ff @(posedge clk) begin
      if (wrStbB) begin
         memArray[wrAddrB] <= wrDataB;
      end
      if (wrStbA) begin
         memArray[wrAddrA] <= wrDataA;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rdDataA <= '0;
         rdDataB <= '0;
      end else begin
         if (rdStbA) begin
            rdDataA <= memArray[rdAddrA];
         end
         if (rdStbB) begin
            rdDataB <= memArray[rdAddrB];
         end
      end
   end

endmodule : ram_dual_mem

// ---- rtl/ram_clock_modes.sv ----
// embedded ram with selectable clocking method and optional read enables
// assumes clkTick0/1 are strobes standing for the two ram clocks, all synchronous to core_clk
// Summary of operation
// - single method: every register uses clock 0 and enable 0 only
// - in/out method: all input registers on clock 0, output registers on clock 1
// - read/write method: write side on clock 0, read address, enable, output on clock 1
// - per-port method: port a registers on clock 0, port b registers on clock 1
// - per-port method: enable 0 gates only port a, enable 1 only port b
// - simple dual-port: read enable input for the read port is optional by config
// - true dual-port: separate optional read enables for port a and port b
// - only three clock methods per port mode; other code refused
`timescale 1ns/1ps
`include "ram_clock_map.svh"

module ram_clock_modes #(
   parameter int ADDR_W = 8,
   parameter int DATA_W = 16
) (
   input  wire logic              core_clk,
   input  wire logic              rst_n,
   input  wire logic              clkEn,
   input  wire logic              psel,
   input  wire logic              penable,
   input  wire logic              pwrite,
   input  wire logic [11:0]       paddr,
   input  wire logic [31:0]       pwdata,
   output logic      [31:0]       prdata,
   output logic                   pready,
   output logic                   pslverr,
   input  wire logic              clkTick0,
   input  wire logic              clkTick1,
   input  wire logic              portEn0,
   input  wire logic              portEn1,
   input  wire logic [DATA_W-1:0] dataA,
   input  wire logic [ADDR_W-1:0] addrA,
   input  wire logic              wrEnA,
   input  wire logic              rdEnA,
   output logic      [DATA_W-1:0] qA,
   input  wire logic [DATA_W-1:0] dataB,
   input  wire logic [ADDR_W-1:0] addrB,
   input  wire logic              wrEnB,
   input  wire logic              rdEnB,
   output logic      [DATA_W-1:0] qB
);

   if (ADDR_W < 1 || ADDR_W > 16) begin : g_chkA
      $error("ram_clock_modes: ADDR_W out of range");
   end
   if (DATA_W < 1 || DATA_W > 32) begin : g_chkD
      $error("ram_clock_modes: DATA_W out of range");
   end

   function automatic logic pickStb(input logic useOne, input logic s0, input logic s1);
      pickStb = useOne ? s1 : s0;
   endfunction : pickStb

   ram_clock_pkg::cfg_s cfg_q;
   ram_clock_pkg::cfg_s cfg_d;
   logic                reject_q;
   logic [ADDR_W-1:0]   addrA_q;
   logic [ADDR_W-1:0]   addrB_q;
   logic                rdEnA_q;
   logic                rdEnB_q;
   logic [31:0]         prdata_d;

   // clock and enable of each register group
   wire stb0       = clkEn & clkTick0 & portEn0;
   wire stb1       = clkEn & clkTick1 & portEn1;
   wire isSingle   = cfg_q.clkMethod == ram_clock_pkg::CLK_SINGLE;
   wire isInOut    = cfg_q.clkMethod == ram_clock_pkg::CLK_IN_OUT;
   wire isSep      = cfg_q.clkMethod == ram_clock_pkg::CLK_SEPARATE;
   wire isTrue     = cfg_q.portMode == ram_clock_pkg::TRUE_DUAL;
   wire inAStb     = stb0;
   wire inBStb     = pickStb(isSep, stb0, stb1);
   wire outAStb    = pickStb(isInOut, stb0, stb1);
   wire outBStb    = pickStb(!isSingle, stb0, stb1);

   // read enables: absent input reads as always asserted
   wire rdEffA     = isTrue & (!cfg_q.rdEnCreateA | rdEnA_q);
   wire rdEffB     = !cfg_q.rdEnCreateB | rdEnB_q;
   wire wrStbA     = inAStb & wrEnA;
   wire wrStbB     = inBStb & wrEnB & isTrue;
   wire rdStbA     = outAStb & rdEffA;
   wire rdStbB     = outBStb & rdEffB;

   // apb decode
   wire apbAcc     = psel & penable & !pready;
   wire hitCfg     = paddr == `RCM_CFG_OFFSET;
   wire hitStat    = paddr == `RCM_STATUS_OFFSET;
   wire badMethod  = pwdata[`RCM_METHOD_MSB:`RCM_METHOD_LSB] == `RCM_METHOD_ILLEGAL;
   wire cfgWr      = apbAcc & pwrite & hitCfg & !badMethod;
   wire cfgBad     = apbAcc & pwrite & hitCfg & badMethod;
   wire statWr     = apbAcc & pwrite & hitStat;
   wire unmapped   = apbAcc & !hitCfg & !hitStat;

   always_comb begin
      cfg_d = cfg_q;
      if (cfgWr) begin
         cfg_d = ram_clock_pkg::cfg_s'(pwdata[`RCM_RDENB_BIT:`RCM_PORTMODE_BIT]);
      end
   end

   always_comb begin
      prdata_d = 32'h00000000;
      if (hitCfg) begin
         prdata_d[`RCM_RDENB_BIT:`RCM_PORTMODE_BIT] = cfg_q;
      end else if (hitStat) begin
         prdata_d[`RCM_REJECT_BIT]                      = reject_q;
         prdata_d[`RCM_STAT_CFG_MSB:`RCM_STAT_CFG_LSB] = cfg_q;
      end
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         cfg_q   <= ram_clock_pkg::cfg_s'(`RCM_CFG_RESET);
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= 32'h00000000;
      end else if (clkEn) begin
         cfg_q   <= cfg_d;
         pready  <= apbAcc;
         pslverr <= cfgBad | unmapped;
         prdata  <= apbAcc ? prdata_d : 32'h00000000;
      end
   end

   // refused configuration flag; a new refusal wins over the clear
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         reject_q <= 1'b0;
      end else if (clkEn) begin
         if (cfgBad) begin
            reject_q <= 1'b1;
         end else if (statWr && pwdata[`RCM_REJECT_BIT]) begin
            reject_q <= 1'b0;
         end
      end
   end

   // input registers of each port
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         addrA_q <= '0;
         rdEnA_q <= 1'b0;
      end else if (inAStb) begin
         addrA_q <= addrA;
         rdEnA_q <= rdEnA;
      end
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         addrB_q <= '0;
         rdEnB_q <= 1'b0;
      end else if (inBStb) begin
         addrB_q <= addrB;
         rdEnB_q <= rdEnB;
      end
   end

   ram_dual_mem #(
      .ADDR_W (ADDR_W),
      .DATA_W (DATA_W)
   ) u_mem (
      .clk     (core_clk),
      .rst_n   (rst_n),
      .wrStbA  (wrStbA),
      .wrAddrA (addrA),
      .wrDataA (dataA),
      .rdStbA  (rdStbA),
      .rdAddrA (addrA_q),
      .rdDataA (qA),
      .wrStbB  (wrStbB),
      .wrAddrB (addrB),
      .wrDataB (dataB),
      .rdStbB  (rdStbB),
      .rdAddrB (addrB_q),
      .rdDataB (qB)
   );

   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (!rst_n);

   sequence badCfgAccess;
      clkEn && psel && penable && !pready && pwrite && hitCfg && badMethod;
   endsequence

   sequence refusedAnswer;
      pready && pslverr ##1 !pready;
   endsequence

   sequence readOnB;
      outBStb && rdEffB;
   endsequence

   single_clk_hold_a: assert property (
      (isSingle && !stb0) |=> $stable(qB) && $stable(addrB_q) && $stable(qA))
      else $error("single clock: register moved without clock 0");

   inout_out_hold_a: assert property (
      (isInOut && !stb1) |=> $stable(qA) && $stable(qB))
      else $error("in/out clock: output moved without clock 1");

   inout_in_take_a: assert property (
      (isInOut && stb0) |=> addrB_q == $past(addrB) && rdEnB_q == $past(rdEnB))
      else $error("in/out clock: input register missed clock 0");

   rdwr_read_side_a: assert property (
      (!isTrue && isSep && !stb1) |=> $stable(addrB_q) && $stable(qB))
      else $error("read/write clock: read side moved without read clock");

   port_a_clock_a: assert property (
      (isTrue && isSep && !stb0) |=> $stable(qA) && $stable(addrA_q))
      else $error("per-port clock: port a moved without clock a");

   port_b_enable_a: assert property (
      (isTrue && isSep && clkEn && clkTick1 && !portEn1) |=> $stable(qB) && $stable(addrB_q))
      else $error("per-port clock: port b moved with its enable low");

   read_gate_b_a: assert property (
      (cfg_q.rdEnCreateB && !rdEnB_q) |=> $stable(qB))
      else $error("read enable low but port b output changed");

   read_gate_a_a: assert property (
      (isTrue && cfg_q.rdEnCreateA && !rdEnA_q) |=> $stable(qA))
      else $error("read enable low but port a output changed");

   method_refuse_a: assert property (
      badCfgAccess |=> refusedAnswer and ($stable(cfg_q) [*2]))
      else $error("illegal clock method was not refused");

   read_free_run_a: assert property (
      (!cfg_q.rdEnCreateB && outBStb) |-> readOnB)
      else $error("port without read enable skipped a read");

   freeze_all_a: assert property (
      !clkEn |=> $stable(qA) && $stable(qB) && $stable(cfg_q) && $stable(pready))
      else $error("state moved while clock enable low");

   freeze_regs_a: assert property (
      !clkEn |=> $stable(addrA_q) && $stable(addrB_q) && $stable(reject_q) && $stable(prdata) && $stable(pslverr))
      else $error("input or status register moved while clock enable low");

   single_common_en_a: assert property (
      (isSingle && stb0) |=> addrA_q == $past(addrA) && addrB_q == $past(addrB))
      else $error("single clock: input register missed the common clock");

   rdwr_write_side_a: assert property (
      (!isTrue && isSep && !stb0) |=> $stable(addrA_q) && $stable(rdEnA_q))
      else $error("read/write clock: write side moved without write clock");

   rdwr_read_take_a: assert property (
      (!isTrue && isSep && stb1) |=> addrB_q == $past(addrB) && rdEnB_q == $past(rdEnB))
      else $error("read/write clock: read address missed the read clock");

   port_b_clock_a: assert property (
      (isTrue && isSep && !stb1) |=> $stable(qB) && $stable(addrB_q) && $stable(rdEnB_q))
      else $error("per-port clock: port b moved without clock b");

   port_a_take_a: assert property (
      (isTrue && isSep && stb0) |=> addrA_q == $past(addrA) && rdEnA_q == $past(rdEnA))
      else $error("per-port clock: port a input missed clock a");

   port_b_take_a: assert property (
      (isTrue && isSep && stb1) |=> addrB_q == $past(addrB) && rdEnB_q == $past(rdEnB))
      else $error("per-port clock: port b input missed clock b");

   port_a_enable_a: assert property (
      (isTrue && isSep && clkEn && clkTick0 && !portEn0) |=> $stable(qA) && $stable(addrA_q))
      else $error("per-port clock: port a moved with its enable low");

   simple_a_quiet_a: assert property (
      !isTrue |=> $stable(qA))
      else $error("simple dual-port: port a output changed");

   reject_set_a: assert property (
      (cfgBad && clkEn) |=> reject_q)
      else $error("refused method did not set the reject flag");

   reject_clear_a: assert property (
      (statWr && pwdata[`RCM_REJECT_BIT] && !cfgBad && clkEn) |=> !reject_q)
      else $error("reject flag not cleared by software");

   cfg_take_a: assert property (
      (cfgWr && clkEn) |=> cfg_q == $past(pwdata[`RCM_RDENB_BIT:`RCM_PORTMODE_BIT]))
      else $error("legal configuration write not taken");

   apb_answer_a: assert property (
      (clkEn && psel && penable && !pready) |=> pready)
      else $error("access phase not answered in the next cycle");

   apb_ready_pulse_a: assert property (
      (pready && clkEn) |=> !pready)
      else $error("ready stood longer than one cycle");

   apb_err_qual_a: assert property (
      pslverr |-> pready)
      else $error("error flag without ready");

   apb_rdata_idle_a: assert property (
      !pready |-> prdata == 32'h00000000)
      else $error("read data not zero outside the answer cycle");

   apb_unmapped_a: assert property (
      (unmapped && clkEn) |=> pready && pslverr)
      else $error("unmapped access not refused");

endmodule : ram_clock_modes

// ---- testbench/ram_fabric.sv ----
// fabric-side model that drives both ram ports, one frame per call
// assumes core_clk is the only clock; the ticks stand for the ram clocks
`timescale 1ns/1ps

module ram_fabric #(
   parameter int ADDR_W = 8,
   parameter int DATA_W = 16
) (
   input  wire logic              core_clk,
   output logic                   clkTick0,
   output logic                   clkTick1,
   output logic                   portEn0,
   output logic                   portEn1,
   output logic      [DATA_W-1:0] dataA,
   output logic      [ADDR_W-1:0] addrA,
   output logic                   wrEnA,
   output logic                   rdEnA,
   output logic      [DATA_W-1:0] dataB,
   output logic      [ADDR_W-1:0] addrB,
   output logic                   wrEnB,
   output logic                   rdEnB
);
   initial begin
      {clkTick0, clkTick1, portEn0, portEn1, wrEnA, rdEnA, wrEnB, rdEnB} = 8'h00;
      {dataA, dataB, addrA, addrB} = '0;
   end

   // one ram clock frame: t = {tick1, tick0}, e = {en1, en0}
   task automatic op(input logic [1:0] t, input logic [1:0] e, input logic wa, input logic ra,
                     input logic [ADDR_W-1:0] aa, input logic [DATA_W-1:0] da, input logic wb,
                     input logic rb, input logic [ADDR_W-1:0] ab, input logic [DATA_W-1:0] db);
      @(posedge core_clk);
      {clkTick1, clkTick0} <= t;
      {portEn1, portEn0} <= e;
      wrEnA <= wa;
      rdEnA <= ra;
      addrA <= aa;
      dataA <= da;
      wrEnB <= wb;
      rdEnB <= rb;
      addrB <= ab;
      dataB <= db;
      @(posedge core_clk);
      {clkTick1, clkTick0} <= 2'h0;
      {wrEnA, wrEnB} <= 2'h0;
      dataA <= ~da;
      dataB <= ~db;
      #1;
   endtask : op
endmodule : ram_fabric

// ---- testbench/tb_top.sv ----
// self-checking bench for the ram clocking block
// assumes the map header and package from rtl/ and the fabric model
`timescale 1ns/1ps
`include "ram_clock_map.svh"

module tb_top;
   logic        core_clk;
   logic        rst_n;
   logic        clkEn;
   logic        psel;
   logic        penable;
   logic        pwrite;
   logic [11:0] paddr;
   logic [31:0] pwdata;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   logic        clkTick0, clkTick1, portEn0, portEn1;
   logic        wrEnA, rdEnA, wrEnB, rdEnB;
   logic [15:0] dataA, dataB, qA, qB;
   logic [7:0]  addrA, addrB;
   logic [31:0] rd;
   logic        err;
   int          fails;
   int          checks_done;

   ram_clock_modes uut (
      .core_clk(core_clk), .rst_n(rst_n), .clkEn(clkEn),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .clkTick0(clkTick0), .clkTick1(clkTick1), .portEn0(portEn0), .portEn1(portEn1),
      .dataA(dataA), .addrA(addrA), .wrEnA(wrEnA), .rdEnA(rdEnA), .qA(qA),
      .dataB(dataB), .addrB(addrB), .wrEnB(wrEnB), .rdEnB(rdEnB), .qB(qB)
   );

   ram_fabric fab (
      .core_clk(core_clk), .clkTick0(clkTick0), .clkTick1(clkTick1),
      .portEn0(portEn0), .portEn1(portEn1),
      .dataA(dataA), .addrA(addrA), .wrEnA(wrEnA), .rdEnA(rdEnA),
      .dataB(dataB), .addrB(addrB), .wrEnB(wrEnB), .rdEnB(rdEnB)
   );

   initial begin
      core_clk = 1'b0;
      forever #5 core_clk = ~core_clk;
   end

   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
      checks_done++;
      if (g !== e) begin
         fails++;
         $display("unexpected %s: expected %h seen %h", n, e, g);
      end
   endtask : chk

   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge core_clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge core_clk);
      penable <= 1'b1;
      do begin
         @(posedge core_clk);
      end while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task automatic wreg(input logic [11:0] a, input logic [31:0] d, input logic e);
      apb(1'b1, a, d);
      chk("pslverr", {31'h0, e}, {31'h0, err});
   endtask : wreg

   task automatic rreg(input logic [11:0] a, input logic [31:0] e);
      apb(1'b0, a, 32'h0);
      chk("prdata", e, rd);
   endtask : rreg

   task give_verdict;
      if (fails == 0 && checks_done > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask : give_verdict

   initial begin
      #100000;
      fails++;
      give_verdict();
   end

   initial begin
      {rst_n, psel, penable, pwrite, paddr, pwdata} = '0;
      clkEn = 1'b1;
      fails = 0;
      checks_done = 0;
      repeat (6) @(posedge core_clk);
      rst_n <= 1'b1;
      rreg(`RCM_CFG_OFFSET, 32'h0);
      rreg(`RCM_STATUS_OFFSET, 32'h0);
      wreg(`RCM_CFG_OFFSET, 32'h6, 1'b1);
      rreg(`RCM_CFG_OFFSET, 32'h0);
      rreg(`RCM_STATUS_OFFSET, 32'h1);
      wreg(`RCM_STATUS_OFFSET, 32'h1, 1'b0);
      wreg(12'h008, 32'h0, 1'b1);
      rreg(12'h008, 32'h0);
      // single clock: clock 1 must not write, read port runs on clock 0
      fab.op(2'h1, 2'h1, 1, 0, 8'h03, 16'hAAAA, 0, 0, 8'h03, 16'h0);
      fab.op(2'h2, 2'h3, 1, 0, 8'h03, 16'h5555, 0, 0, 8'h03, 16'h0);
      fab.op(2'h1, 2'h1, 0, 0, 8'h03, 16'h0, 0, 0, 8'h03, 16'h0);
      chk("qB", 32'hAAAA, {16'h0, qB});
      // read/write clocks: read address follows clock 1 only
      wreg(`RCM_CFG_OFFSET, 32'h4, 1'b0);
      fab.op(2'h1, 2'h1, 1, 0, 8'h04, 16'h1111, 0, 0, 8'h04, 16'h0);
      fab.op(2'h2, 2'h2, 0, 0, 8'h04, 16'h0, 0, 0, 8'h04, 16'h0);
      fab.op(2'h1, 2'h1, 0, 0, 8'h04, 16'h0, 0, 0, 8'h03, 16'h0);
      fab.op(2'h2, 2'h2, 0, 0, 8'h04, 16'h0, 0, 0, 8'h03, 16'h0);
      chk("qB", 32'h1111, {16'h0, qB});
      // input/output clocks
      wreg(`RCM_CFG_OFFSET, 32'h2, 1'b0);
      fab.op(2'h1, 2'h1, 0, 0, 8'h00, 16'h0, 0, 0, 8'h04, 16'h0);
      fab.op(2'h2, 2'h2, 0, 0, 8'h00, 16'h0, 0, 0, 8'h03, 16'h0);
      chk("qB", 32'h1111, {16'h0, qB});
      // read enable created for the read port
      wreg(`RCM_CFG_OFFSET, 32'h12, 1'b0);
      fab.op(2'h1, 2'h1, 0, 0, 8'h00, 16'h0, 0, 0, 8'h03, 16'h0);
      fab.op(2'h2, 2'h2, 0, 0, 8'h00, 16'h0, 0, 0, 8'h03, 16'h0);
      chk("qB", 32'h1111, {16'h0, qB});
      fab.op(2'h1, 2'h1, 0, 0, 8'h00, 16'h0, 0, 1, 8'h03, 16'h0);
      fab.op(2'h2, 2'h2, 0, 0, 8'h00, 16'h0, 0, 1, 8'h03, 16'h0);
      chk("qB", 32'hAAAA, {16'h0, qB});
      // true dual, clocks per port, both read enables
      wreg(`RCM_CFG_OFFSET, 32'h1D, 1'b0);
      rreg(`RCM_STATUS_OFFSET, 32'h1D00);
      fab.op(2'h2, 2'h2, 0, 0, 8'h00, 16'h0, 1, 0, 8'h06, 16'hBBBB);
      fab.op(2'h2, 2'h1, 0, 0, 8'h00, 16'h0, 1, 0, 8'h06, 16'hCCCC);
      fab.op(2'h1, 2'h1, 0, 1, 8'h06, 16'h0, 0, 0, 8'h06, 16'h0);
      fab.op(2'h1, 2'h1, 0, 1, 8'h06, 16'h0, 0, 0, 8'h06, 16'h0);
      chk("qA", 32'hBBBB, {16'h0, qA});
      fab.op(2'h3, 2'h3, 0, 0, 8'h03, 16'h0, 0, 1, 8'h06, 16'h0);
      fab.op(2'h3, 2'h3, 0, 0, 8'h03, 16'h0, 0, 1, 8'h06, 16'h0);
      chk("qA", 32'hBBBB, {16'h0, qA});
      chk("qB", 32'hBBBB, {16'h0, qB});
      // clock enable low: port b strobes must not move anything
      @(posedge core_clk);
      clkEn <= 1'b0;
      fab.op(2'h2, 2'h3, 0, 0, 8'h03, 16'h0, 0, 1, 8'h03, 16'h0);
      fab.op(2'h2, 2'h3, 0, 0, 8'h03, 16'h0, 0, 1, 8'h03, 16'h0);
      @(posedge core_clk);
      clkEn <= 1'b1;
      chk("qB", 32'hBBBB, {16'h0, qB});
      fab.op(2'h2, 2'h2, 0, 0, 8'h03, 16'h0, 0, 1, 8'h03, 16'h0);
      fab.op(2'h2, 2'h2, 0, 0, 8'h03, 16'h0, 0, 1, 8'h03, 16'h0);
      chk("qB", 32'hAAAA, {16'h0, qB});
      give_verdict();
   end
endmodule : tb_top
